// *** hw/mrc_reset_ctrl.sv ***
// reset controller: pin, software and watchdog sources, sequencer, pin states
// assumes clk at 200 MHz, rst_b as power-on reset, an apb master on the bus
//
// Behaviour
// - low reset pin enters hardware reset
// - pin low initialises pins, starts oscillator
// - cpu and registers initialised at pin rise
// - cpu fetches from vector after hardware reset
// - hardware reset leaves internal ram alone
// - ram write cut by reset is undefined
// - boot high: selects and strobes driven high
// - boot high: address undefined, data input
// - boot high: yield inputs, grant follows request
// - pull-ups not relied on before settling
// - writing software reset bit resets device
// - software reset end: init, fetch vector
// - software reset keeps processor mode bits
// - watchdog resets only when select bit set
// - watchdog reset end: init, fetch vector
// - watchdog reset keeps processor mode bits
// - vector bits 31..2 give start address
// - vector bits 1..0 select bus width
//
// Design decisions made here: register access over APB and the address map.
`include "mrc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mrc_reset_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // reset sources, boot strap, bus-yield request and reset vector
  input  wire logic        resetPin_b,
  input  wire logic        wdtUnderflow,
  input  wire logic        bootModePin,
  input  wire logic        busYieldReq,
  input  wire logic [31:0] resetVector,
  // cpu side
  output var  logic        cpuReset,
  output var  logic        sfrInit,
  output var  logic        cpuStart,
  output var  logic [31:0] startAddr,
  output var  logic [1:0]  busWidth,
  output var  logic [1:0]  procModeSel,
  output var  logic        oscEnable,
  // pin state control during reset
  output var  logic        chipSelect0_b,
  output var  logic        chipSelect2_b,
  output var  logic        writeStrobe_b,
  output var  logic        readStrobe_b,
  output var  logic        ctrlPinOe,
  output var  logic        addrOe,
  output var  logic        byteLaneCtrl1Oe,
  output var  logic        dataOe,
  output var  logic        busYieldGrant,
  output var  logic        busYieldGrantOe,
  output var  logic        pullUpEnable
);
  import mrc_pkg::*;

  logic        rstMeta;    // reset release stage 1
  logic        rstSync;    // released reset used by the design
  mrc_regs_t   r;          // registered state
  mrc_regs_t   next_r;     // next state
  logic        apbAccess;  // completing access phase
  logic        apbWrite;   // completing write
  logic        swFire;     // software reset request written
  logic        wdtFire;    // qualified watchdog underflow
  logic        pinLow;     // synchronised reset pin low
  logic        mapped;     // address hits a register

  // address decode, used by the error path only
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `MRC_OFF_PMODE0) || (a == `MRC_OFF_CLKCTL0) ||
               (a == `MRC_OFF_STATUS) || (a == `MRC_OFF_VECTOR);
  endfunction

  // release of the power-on reset through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // event terms read by the next-state logic
  always_comb begin
    apbAccess = psel && penable && r.pready;
    apbWrite  = apbAccess && pwrite;
    mapped    = isMapped(paddr);
    pinLow    = !r.pinSync2;
    swFire    = apbWrite && (paddr == `MRC_OFF_PMODE0) && pwdata[`MRC_PM_SWRST];
    wdtFire   = wdtUnderflow && r.wdtSel;
  end

  // next state of the whole controller
  always_comb begin
    next_r          = r;
    // synchronisers: stage 1 read only by stage 2
    next_r.pinSync1   = resetPin_b;
    next_r.pinSync2   = r.pinSync1;
    next_r.bootSync1  = bootModePin;
    next_r.bootSync2  = r.bootSync1;
    next_r.yieldSync1 = busYieldReq;
    next_r.yieldSync2 = r.yieldSync1;
    // one-cycle pulses default low
    next_r.sfrInit    = 1'b0;
    next_r.cpuStart   = 1'b0;
    next_r.pslverr    = 1'b0;

    // apb: ready one cycle after setup, never two in a row
    next_r.pready = psel && !penable;
    if (psel && !penable) begin
      next_r.pslverr = !mapped;
      case (paddr)
        `MRC_OFF_PMODE0:  next_r.prdata = {30'h0000_0000, r.modeSel};  // request bit reads zero
        `MRC_OFF_CLKCTL0: next_r.prdata = {25'h000_0000, r.wdtSel, 6'h00};
        `MRC_OFF_STATUS:  next_r.prdata = {23'h00_0000, r.st != ST_RUN, 5'h00, r.cause};
        `MRC_OFF_VECTOR:  next_r.prdata = {r.startAddr[31:2], r.busWidth};
        default:          next_r.prdata = 32'h0000_0000;
      endcase
    end

    // register writes; processor mode bits change by software or at pin reset init
    if (apbWrite && paddr == `MRC_OFF_PMODE0) begin
      next_r.modeSel = pwdata[`MRC_PM_SEL_HI:`MRC_PM_SEL_LO];
    end
    if (apbWrite && paddr == `MRC_OFF_CLKCTL0) begin
      next_r.wdtSel = pwdata[`MRC_CM_WDTSEL];
    end
    // cause flags: write one clears, a new set below wins
    if (apbWrite && paddr == `MRC_OFF_STATUS) begin
      next_r.cause = r.cause & ~pwdata[2:0];
    end

    // oscillator starts the cycle after the synchronised pin reads low and stays on
    if (pinLow) begin
      next_r.oscEn = 1'b1;
    end

    // reset sequencer
    case (r.st)
      ST_RUN: begin
        if (pinLow || swFire || wdtFire) begin
          next_r.st     = ST_HOLD;
          next_r.cpuRst = 1'b1;
          next_r.holdCnt = `MRC_INT_HOLD_CYC;
          // pin has priority when sources coincide
          if (pinLow) begin
            next_r.lastSrc = SRC_PIN;
            next_r.cause[`MRC_ST_CAUSE_PIN] = 1'b1;
          end else if (swFire) begin
            next_r.lastSrc = SRC_SW;
            next_r.cause[`MRC_ST_CAUSE_SW] = 1'b1;
          end else begin
            next_r.lastSrc = SRC_WDT;
            next_r.cause[`MRC_ST_CAUSE_WDT] = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // nothing is initialised while the pin stays low
        if (r.holdCnt != 4'h0) begin
          next_r.holdCnt = r.holdCnt - 4'h1;
        end
        if (pinLow) begin
          // a pin reset overriding an internal one is a hardware reset
          next_r.lastSrc = SRC_PIN;
          next_r.cause[`MRC_ST_CAUSE_PIN] = 1'b1;
        end else if (r.holdCnt == 4'h0) begin
          next_r.st      = ST_INIT;
          next_r.sfrInit = 1'b1;
        end
      end
      ST_INIT: begin
        // registers take reset values; ram is outside, nothing here clears it
        next_r.wdtSel = `MRC_RST_WDTSEL;
        if (r.lastSrc == SRC_PIN) begin
          next_r.modeSel = `MRC_RST_MODESEL;
        end
        // software and watchdog resets leave modeSel alone
        next_r.st = ST_VECT;
      end
      ST_VECT: begin
        // low two bits of the address forced to zero
        next_r.startAddr = {resetVector[31:`MRC_VEC_ADDR_LSB], 2'b00};
        next_r.busWidth  = resetVector[`MRC_VEC_ADDR_LSB-1:`MRC_VEC_WIDTH_LSB];
        next_r.cpuRst    = 1'b0;
        next_r.cpuStart  = 1'b1;
        next_r.st        = ST_RUN;
      end
      default: begin
        next_r.st = ST_HOLD;
      end
    endcase

    // pin states while held: driven from the next state so they follow at once
    next_r.cs0        = 1'b1;
    next_r.cs2        = 1'b1;
    next_r.wrB        = 1'b1;
    next_r.rdB        = 1'b1;
    next_r.grant      = r.yieldSync2;
    next_r.ctrlOe     = 1'b0;
    next_r.addrOe     = 1'b0;
    next_r.byteLaneOe = 1'b0;
    next_r.dataOe     = 1'b0;
    next_r.grantOe    = 1'b0;
    // pull-ups stay off during reset, state before settling is unknown
    next_r.pullUpEn   = (next_r.st == ST_RUN);
    if (next_r.st != ST_RUN && r.bootSync2) begin
      next_r.ctrlOe     = 1'b1;
      next_r.addrOe     = 1'b1;
      next_r.byteLaneOe = 1'b1;
      next_r.grantOe    = 1'b1;
    end
    // boot low: every enable already off
  end

  // single state register, constants only under reset
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      r            <= '0;
      r.st         <= ST_HOLD;
      r.lastSrc    <= SRC_PIN;
      r.cpuRst     <= 1'b1;
      r.cause      <= `MRC_RST_CAUSE;
      r.cs0        <= 1'b1;
      r.cs2        <= 1'b1;
      r.wrB        <= 1'b1;
      r.rdB        <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  always_comb begin
    prdata          = r.prdata;
    pready          = r.pready;
    pslverr         = r.pslverr;
    cpuReset        = r.cpuRst;
    sfrInit         = r.sfrInit;
    cpuStart        = r.cpuStart;
    startAddr       = r.startAddr;
    busWidth        = r.busWidth;
    procModeSel     = r.modeSel;
    oscEnable       = r.oscEn;
    chipSelect0_b   = r.cs0;
    chipSelect2_b   = r.cs2;
    writeStrobe_b   = r.wrB;
    readStrobe_b    = r.rdB;
    ctrlPinOe       = r.ctrlOe;
    addrOe          = r.addrOe;
    byteLaneCtrl1Oe = r.byteLaneOe;
    dataOe          = r.dataOe;
    busYieldGrant   = r.grant;
    busYieldGrantOe = r.grantOe;
    pullUpEnable    = r.pullUpEn;
  end

  // a low pin while running holds the cpu next cycle
  property p_pin_enters;
    @(posedge clk) disable iff (!rstSync)
      (r.st == ST_RUN && pinLow) |=> (r.cpuRst && r.st == ST_HOLD);
  endproperty
  a_pin_enters: assert property (p_pin_enters) else $error("pin low did not enter reset");

  // init pulse only once the pin is high again
  property p_init_on_rise;
    @(posedge clk) disable iff (!rstSync)
      r.sfrInit |-> (r.pinSync2 && $past(r.st) == ST_HOLD);
  endproperty
  a_init_on_rise: assert property (p_init_on_rise) else $error("init while pin low");

  // start follows init by exactly two cycles
  property p_start_after_init;
    @(posedge clk) disable iff (!rstSync)
      r.sfrInit |-> ##2 (r.cpuStart && !r.cpuRst);
  endproperty
  a_start_after_init: assert property (p_start_after_init) else $error("no start after init");

  // software request written leads to held reset
  property p_sw_reset;
    @(posedge clk) disable iff (!rstSync)
      (r.st == ST_RUN && swFire && !pinLow) |=> (r.cpuRst && r.lastSrc == SRC_SW);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset not taken");

  // internal reset keeps processor mode across init
  property p_mode_kept;
    @(posedge clk) disable iff (!rstSync)
      (r.st == ST_INIT && r.lastSrc != SRC_PIN) |=> (r.modeSel == $past(r.modeSel));
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("mode bits changed");

  // underflow without select bit leaves the cpu running
  property p_wdt_gated;
    @(posedge clk) disable iff (!rstSync)
      (r.st == ST_RUN && wdtUnderflow && !r.wdtSel && !pinLow && !swFire) |=> (r.st == ST_RUN);
  endproperty
  a_wdt_gated: assert property (p_wdt_gated) else $error("ungated watchdog reset");

  // start address is word aligned and matches the vector
  property p_vector_split;
    @(posedge clk) disable iff (!rstSync)
      r.cpuStart |-> (r.startAddr[1:0] == 2'b00 &&
                      r.startAddr[31:2] == $past(resetVector[31:2]) &&
                      r.busWidth == $past(resetVector[1:0]));
  endproperty
  a_vector_split: assert property (p_vector_split) else $error("vector decode wrong");

  // strobes high and data released whenever driven
  property p_strobes_high;
    @(posedge clk) disable iff (!rstSync)
      r.ctrlOe |-> (r.cs0 && r.cs2 && r.wrB && r.rdB && !r.dataOe && r.cpuRst);
  endproperty
  a_strobes_high: assert property (p_strobes_high) else $error("strobe state wrong");

  // grant mirrors the synchronised request
  property p_grant_follows;
    @(posedge clk) disable iff (!rstSync)
      r.grantOe |-> (r.grant == $past(r.yieldSync2));
  endproperty
  a_grant_follows: assert property (p_grant_follows) else $error("grant not following");

  // boot low keeps control, address and grant enables off in reset
  property p_boot_low_hiz;
    @(posedge clk) disable iff (!rstSync)
      (r.st != ST_RUN && !$past(r.bootSync2)) |-> !(r.ctrlOe || r.addrOe || r.grantOe);
  endproperty
  a_boot_low_hiz: assert property (p_boot_low_hiz) else $error("pin driven in boot low");

endmodule // mrc_reset_ctrl

`default_nettype wire

// *** hw/mrc_consts.svh ***
// offsets, field positions, reset values and counts of the reset controller
// assumes inclusion by bare name from the design module and the bench
`ifndef MRC_CONSTS_SVH
`define MRC_CONSTS_SVH

// apb word offsets (byte addresses)
`define MRC_OFF_PMODE0      8'h00
`define MRC_OFF_CLKCTL0     8'h04
`define MRC_OFF_STATUS      8'h08
`define MRC_OFF_VECTOR      8'h0C

// processor_mode_reg0 fields
`define MRC_PM_SEL_LO       0
`define MRC_PM_SEL_HI       1
`define MRC_PM_SWRST        3
// system_clock_ctrl_reg0 field
`define MRC_CM_WDTSEL       6
// status fields
`define MRC_ST_CAUSE_PIN    0
`define MRC_ST_CAUSE_SW     1
`define MRC_ST_CAUSE_WDT    2
`define MRC_ST_IN_RESET     8
// reset vector fields
`define MRC_VEC_WIDTH_LSB   0
`define MRC_VEC_ADDR_LSB    2

// reset values
`define MRC_RST_MODESEL     2'h0
`define MRC_RST_WDTSEL      1'h0
`define MRC_RST_CAUSE       3'h1

// hold time of a software or watchdog reset, in clock cycles
`define MRC_INT_HOLD_CYC    4'h8

`endif

// *** hw/mrc_pkg.sv ***
// types of the reset controller: state enumeration and the state record
// assumes mrc_consts.svh sits beside it
`default_nettype none

package mrc_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN,   // cpu running
    ST_HOLD,  // a source holds reset
    ST_INIT,  // cpu and registers initialised
    ST_VECT   // start address taken from the vector
  } mrc_state_t;

  // source of the last reset
  typedef enum logic [1:0] {
    SRC_PIN,
    SRC_SW,
    SRC_WDT
  } mrc_src_t;

  // state of the controller apart from the reset release flops
  typedef struct packed {
    mrc_state_t  st;          // sequencer state
    mrc_src_t    lastSrc;     // source of current/last reset
    logic [3:0]  holdCnt;     // hold counter for internal sources
    logic        pinSync1;    // reset pin sync stage 1
    logic        pinSync2;    // reset pin sync stage 2
    logic        bootSync1;   // boot mode pin sync stage 1
    logic        bootSync2;   // boot mode pin sync stage 2
    logic        yieldSync1;  // bus-yield request sync stage 1
    logic        yieldSync2;  // bus-yield request sync stage 2
    logic [1:0]  modeSel;     // processor mode select bits
    logic        wdtSel;      // watchdog reset select
    logic [2:0]  cause;       // sticky cause flags
    logic        pready;      // apb ready
    logic        pslverr;     // apb error
    logic [31:0] prdata;      // apb read data
    logic        cpuRst;      // cpu held in reset
    logic        sfrInit;     // register init pulse
    logic        cpuStart;    // fetch start pulse
    logic [31:0] startAddr;   // word-aligned start address
    logic [1:0]  busWidth;    // external bus width code
    logic        oscEn;       // main oscillator enable
    logic        cs0;         // chip select 0 level
    logic        cs2;         // chip select 2 level
    logic        wrB;         // write strobe level
    logic        rdB;         // read strobe level
    logic        ctrlOe;      // enable of strobes and selects
    logic        addrOe;      // enable of address outputs
    logic        byteLaneOe;  // enable of byte-lane output
    logic        dataOe;      // enable of data port
    logic        grant;       // bus-yield grant level
    logic        grantOe;     // enable of bus-yield grant
    logic        pullUpEn;    // pull-up enable
  } mrc_regs_t;

endpackage

`default_nettype wire

// *** tb/mrc_ext_reset_model.sv ***
// far-side model: external reset circuit and main oscillator input source
// assumes the bench clock paces it; go is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none

module mrc_ext_reset_model #(
  parameter int SETTLE_CYC = 16  // stand-in for the power-to-release delay
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       powerOn,
  input  wire logic [7:0] oscCycles,
  output var  logic       resetPin_b,
  output var  logic       mainOscInput,
  output var  logic       busy
);
  logic [8:0] halfCnt;    // oscillator half periods still owed
  logic [7:0] settleCnt;  // internal supply settling wait

  initial begin
    resetPin_b   = 1'b1;
    mainOscInput = 1'b0;
    busy         = 1'b0;
    halfCnt      = 9'h000;
    settleCnt    = 8'h00;
  end

  // pin low first, settle, then never fewer than 20 full oscillator cycles
  always @(posedge clk) begin
    if (go && !busy) begin
      busy       <= 1'b1;
      resetPin_b <= 1'b0;
      halfCnt    <= (oscCycles < 8'h14) ? 9'h028 : {oscCycles, 1'b0};
      settleCnt  <= powerOn ? 8'(SETTLE_CYC) : 8'h00;
    end else if (busy) begin
      if (settleCnt != 8'h00) begin
        settleCnt <= settleCnt - 8'h01;
      end else if (halfCnt != 9'h000) begin
        halfCnt      <= halfCnt - 9'h001;
        mainOscInput <= ~mainOscInput;
      end else begin
        resetPin_b <= 1'b1;
        busy       <= 1'b0;
      end
    end
  end
endmodule // mrc_ext_reset_model

`default_nettype wire

// *** tb/mrc_reset_ctrl_tb.sv ***
// self-checking bench of the reset controller: apb master, scoreboard queues
// assumes mrc_consts.svh on the include path and the far-side reset model
`include "mrc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mrc_reset_ctrl_tb;
  logic clk = 1'b0, rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, startAddr, resetVector = 32'h0000_0000, vec;
  logic pready, pslverr, resetPin_b, wdtUnderflow = 1'b0, bootModePin = 1'b0, busYieldReq = 1'b0;
  logic cpuReset, sfrInit, cpuStart, oscEnable, chipSelect0_b, chipSelect2_b, writeStrobe_b;
  logic readStrobe_b, ctrlPinOe, addrOe, byteLaneCtrl1Oe, dataOe, busYieldGrant, busYieldGrantOe;
  logic pullUpEnable, go = 1'b0, powerOn = 1'b0, busy, mainOscInput;
  logic [1:0] initSeen = 2'b00;  // init pulse seen one and two edges ago
  logic [1:0] busWidth, procModeSel, mode;
  logic [7:0] oscCycles = 8'h14;
  logic [33:0] apbQ[$], e;     // {read, error, data}
  logic [35:0] startQ[$], s;   // {mode, width, address}
  int numErrors = 0, samplesChecked = 0;

  always #2.5 clk = ~clk;

  mrc_reset_ctrl i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetPin_b(resetPin_b), .wdtUnderflow(wdtUnderflow), .bootModePin(bootModePin),
    .busYieldReq(busYieldReq), .resetVector(resetVector), .cpuReset(cpuReset), .sfrInit(sfrInit),
    .cpuStart(cpuStart), .startAddr(startAddr), .busWidth(busWidth), .procModeSel(procModeSel),
    .oscEnable(oscEnable), .chipSelect0_b(chipSelect0_b), .chipSelect2_b(chipSelect2_b),
    .writeStrobe_b(writeStrobe_b), .readStrobe_b(readStrobe_b), .ctrlPinOe(ctrlPinOe), .addrOe(addrOe),
    .byteLaneCtrl1Oe(byteLaneCtrl1Oe), .dataOe(dataOe), .busYieldGrant(busYieldGrant),
    .busYieldGrantOe(busYieldGrantOe), .pullUpEnable(pullUpEnable));

  mrc_ext_reset_model i_ext (.clk(clk), .go(go), .powerOn(powerOn), .oscCycles(oscCycles),
    .resetPin_b(resetPin_b), .mainOscInput(mainOscInput), .busy(busy));

  task automatic tallyAndFinish;
    if (numErrors == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the watcher compares the answer against the note
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] exp);
    int n;
    n = 0;
    apbQ.push_back({~wr, err, exp});
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready && ++n < 50);
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin numErrors++; tallyAndFinish(); end
  endtask

  // new random vector, note of the restart that must follow
  task automatic arm_start(input logic [1:0] m);
    vec = $urandom();
    if (m == 2'h0) vec[1:0] = 2'b00;
    resetVector <= vec;
    startQ.push_back({m, vec[1:0], vec[31:2], 2'b00});
  endtask

  task automatic wait_start;
    int n;
    n = 0;
    do @(posedge clk); while (!cpuStart && ++n < 400);
    if (n >= 400) begin numErrors++; tallyAndFinish(); end
  endtask

  task automatic pulse_wdt;
    @(posedge clk) wdtUnderflow <= 1'b1;
    @(posedge clk) wdtUnderflow <= 1'b0;
  endtask

  // watcher: each answer takes the oldest note off its queue
  always @(posedge clk) begin
    initSeen <= {initSeen[0], sfrInit};
    if (pready) begin
      if (apbQ.size() == 0) check(32'h0000_0001, 32'h0000_0000);
      else begin
        e = apbQ.pop_front();
        check({31'h0, pslverr}, {31'h0, e[32]});
        if (e[33]) check(prdata, e[31:0]);
      end
    end
    if (cpuStart) begin
      if (startQ.size() == 0) check(32'h0000_0002, 32'h0000_0000);
      else begin
        s = startQ.pop_front();
        check(startAddr, s[31:0]);
        check({30'h0, busWidth}, {30'h0, s[33:32]});
        check({30'h0, procModeSel}, {30'h0, s[35:34]});
        check({31'h0, initSeen[1]}, 32'h0000_0001);
      end
    end
  end

  initial begin
    void'($urandom(14657));
    arm_start(2'h0);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wait_start();
    apb(0, `MRC_OFF_STATUS, 32'h0, 1'b0, 32'h0000_0001);
    apb(0, `MRC_OFF_PMODE0, 32'h0, 1'b0, 32'h0000_0000);
    apb(0, `MRC_OFF_CLKCTL0, 32'h0, 1'b0, 32'h0000_0000);
    // software reset keeps a random processor mode
    mode = 2'($urandom_range(1, 3));
    apb(1, `MRC_OFF_PMODE0, {30'h0, mode}, 1'b0, 32'h0);
    apb(1, `MRC_OFF_STATUS, 32'h0000_0007, 1'b0, 32'h0);
    apb(0, `MRC_OFF_STATUS, 32'h0, 1'b0, 32'h0000_0000);
    arm_start(mode);
    apb(1, `MRC_OFF_PMODE0, {28'h0, 2'b10, mode}, 1'b0, 32'h0);
    wait_start();
    apb(0, `MRC_OFF_STATUS, 32'h0, 1'b0, 32'h0000_0002);
    apb(0, `MRC_OFF_PMODE0, 32'h0, 1'b0, {30'h0, mode});
    // watchdog underflow ignored while the select bit is clear
    pulse_wdt();
    repeat (20) @(posedge clk);
    check({31'h0, cpuReset}, 32'h0000_0000);
    apb(1, `MRC_OFF_CLKCTL0, 32'h0000_0040, 1'b0, 32'h0);
    apb(0, `MRC_OFF_CLKCTL0, 32'h0, 1'b0, 32'h0000_0040);
    apb(1, `MRC_OFF_STATUS, 32'h0000_0007, 1'b0, 32'h0);
    arm_start(mode);
    pulse_wdt();
    wait_start();
    apb(0, `MRC_OFF_CLKCTL0, 32'h0, 1'b0, 32'h0000_0000);
    apb(0, `MRC_OFF_STATUS, 32'h0, 1'b0, 32'h0000_0004);
    apb(0, `MRC_OFF_PMODE0, 32'h0, 1'b0, {30'h0, mode});
    // pin reset, boot strap high, power-on style with settling
    bootModePin <= 1'b1; busYieldReq <= 1'b1; powerOn <= 1'b1; oscCycles <= 8'h30;
    apb(1, `MRC_OFF_STATUS, 32'h0000_0007, 1'b0, 32'h0);
    arm_start(2'h0);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (12) @(posedge clk);
    check({19'h0, cpuReset, oscEnable, chipSelect0_b, chipSelect2_b, writeStrobe_b, readStrobe_b,
           ctrlPinOe, addrOe, byteLaneCtrl1Oe, dataOe, busYieldGrantOe, busYieldGrant, pullUpEnable},
          32'h0000_1FF6);
    apb(0, `MRC_OFF_STATUS, 32'h0, 1'b0, 32'h0000_0101);
    busYieldReq <= 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0, busYieldGrant}, 32'h0000_0000);
    wait_start();
    apb(0, `MRC_OFF_PMODE0, 32'h0, 1'b0, 32'h0000_0000);
    // pin reset, boot strap low, short request clamped by the partner
    bootModePin <= 1'b0; powerOn <= 1'b0; oscCycles <= 8'h05;
    arm_start(2'h0);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (12) @(posedge clk);
    check({19'h0, cpuReset, oscEnable, chipSelect0_b, chipSelect2_b, writeStrobe_b, readStrobe_b,
           ctrlPinOe, addrOe, byteLaneCtrl1Oe, dataOe, busYieldGrantOe, busYieldGrant, pullUpEnable},
          32'h0000_1F80);
    wait_start();
    // vector readback and unmapped places
    apb(0, `MRC_OFF_VECTOR, 32'h0, 1'b0, vec);
    apb(1, 8'h40, 32'hFFFF_FFFF, 1'b1, 32'h0);
    apb(0, 8'h10, 32'h0, 1'b1, 32'h0000_0000);
    repeat (4) @(posedge clk);
    if (apbQ.size() != 0 || startQ.size() != 0) numErrors++;
    tallyAndFinish();
  end
endmodule // mrc_reset_ctrl_tb

`default_nettype wire
